//--- hw/flc_pkg.sv
package flc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_OFFSET      = 8'h00;
  localparam logic [7:0] DIM_OFFSET      = 8'h01;
  localparam logic [7:0] AUX_OFFSET      = 8'h02;
  localparam logic [7:0] STAT_OFFSET     = 8'h03;
  localparam logic [7:0] CMD_RESET       = 8'h00;
  localparam logic [7:0] DIM_RESET       = 8'h00;
  localparam logic [7:0] AUX_RESET       = 8'h00;
  localparam logic [7:0] STAT_RESET      = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POWER_UP_BIT   = 7;
  localparam int SOFT_HW_TRIGGER_PIN_BIT  = 6;
  localparam int TORCH_EN_BIT   = 5;
  localparam int TEMP_MON_BIT   = 4;
  localparam int FLASH_TIME_LSB = 0;
  localparam int TORCH_LVL_LSB  = 4;
  localparam int FLASH_LVL_LSB  = 0;
  localparam int IND_CUR_LSB    = 4;
  localparam int IND_TIME_LSB   = 0;
  localparam int SHORTED_BIT    = 7;
  localparam int FLASH_RUN_BIT  = 6;
  localparam int OPEN_BIT       = 5;
  localparam int TEMP_WARN_BIT  = 4;
  localparam int TEMP_HIGH_BIT  = 3;
  localparam int CHIP_OT_BIT    = 2;
  localparam int OVERCUR_BIT    = 1;
  localparam int OUT_NOK_BIT    = 0;
  localparam logic [7:0] LATCHED_MASK    = 8'hBD;
  localparam logic [3:0] FLASH_INDEX_OFS = 4'h5;
  localparam logic [3:0] IND_CONTINUOUS  = 4'hF;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int TICK_PERIOD_MS = 100;
  localparam int CORE_CLK_KHZ   = 100000;
  localparam int TICK_CYCLES    = TICK_PERIOD_MS * CORE_CLK_KHZ;
  localparam int OPEN_FILTER    = 3;

  // arbitrary value, normally set by the address strap
  localparam logic [6:0] SLAVE_ADDR = 7'h30;

  typedef enum logic [1:0] {
    MODE_SHUTDOWN = 2'h0,
    MODE_READY    = 2'h1,
    MODE_TORCH    = 2'h3,
    MODE_FLASH    = 2'h2
  } flc_mode_type;

  typedef enum logic [2:0] {
    SER_IDLE    = 3'h0,
    SER_DEVADDR = 3'h1,
    SER_SUBADDR = 3'h3,
    SER_WDATA   = 3'h2,
    SER_RDATA   = 3'h6
  } flc_ser_type;

endpackage

//--- hw/flc_tick_gen.sv
`timescale 1ns/1ps
module flc_tick_gen #(
  parameter int TICK_CYCLES = flc_pkg::TICK_CYCLES
) (
  input  wire logic clk,   // core clock
  input  wire logic rst_n, // async reset
  output logic      tick   // one-cycle pulse every step
);

  logic [23:0] div_reg;

  // free-running divider for the step enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 24'h000000;
      tick    <= 1'b0;
    end else if (div_reg == 24'(TICK_CYCLES - 1)) begin
      div_reg <= 24'h000000;
      tick    <= 1'b1;
    end else begin
      div_reg <= div_reg + 24'h000001;
      tick    <= 1'b0;
    end
  end

endmodule

//--- hw/flc_i2c_slave.sv
`timescale 1ns/1ps
module flc_i2c_slave (
  input  wire logic       clk,      // core clock
  input  wire logic       rst_n,    // async reset
  input  wire logic       scl_in,   // serial clock pin
  input  wire logic       sda_in,   // serial data pin
  output logic            sda_oe,   // pull data low
  input  wire logic [7:0] rd_data,  // value at ptr
  output logic [7:0]      ptr,      // register pointer
  output logic            wr_stb,   // write pulse
  output logic [7:0]      wr_data,  // write value
  output logic            rd_stb    // byte loaded for send
);

  logic [1:0]  scl_meta, sda_meta;
  logic [1:0]  scl_sync, sda_sync;
  logic [7:0]  sh_reg;
  logic [3:0]  cnt_reg;
  logic        ack_reg, rw_reg;
  flc_pkg::flc_ser_type st_reg;

  wire scl_rise = scl_sync[0] & ~scl_sync[1];
  wire scl_fall = ~scl_sync[0] & scl_sync[1];
  wire start_c  = scl_sync[0] & scl_sync[1] & ~sda_sync[0] & sda_sync[1];
  wire stop_c   = scl_sync[0] & scl_sync[1] & sda_sync[0] & ~sda_sync[1];

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_meta <= 2'h3;
      sda_meta <= 2'h3;
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end else begin
      scl_meta <= {scl_meta[0], scl_in};
      sda_meta <= {sda_meta[0], sda_in};
      scl_sync <= {scl_sync[0], scl_meta[1]};
      sda_sync <= {sda_sync[0], sda_meta[1]};
    end
  end

  // ----------------------------------------------------------------
  // byte engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg  <= flc_pkg::SER_IDLE;
      sh_reg  <= 8'h00;
      cnt_reg <= 4'h0;
      ack_reg <= 1'b0;
      rw_reg  <= 1'b0;
      sda_oe  <= 1'b0;
      ptr     <= 8'h00;
      wr_stb  <= 1'b0;
      wr_data <= 8'h00;
      rd_stb  <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      if (start_c) begin
        st_reg  <= flc_pkg::SER_DEVADDR;
        cnt_reg <= 4'h0;
        ack_reg <= 1'b0;
        sda_oe  <= 1'b0;
      end else if (stop_c) begin
        st_reg <= flc_pkg::SER_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise && st_reg != flc_pkg::SER_IDLE) begin
        if (!ack_reg) begin
          cnt_reg <= cnt_reg + 4'h1;
          if (st_reg != flc_pkg::SER_RDATA) sh_reg <= {sh_reg[6:0], sda_sync[0]};
        end else if (st_reg == flc_pkg::SER_RDATA && sda_sync[0]) begin
          st_reg <= flc_pkg::SER_IDLE;
        end
      end else if (scl_fall && st_reg != flc_pkg::SER_IDLE) begin
        if (!ack_reg && cnt_reg == 4'h8) begin
          ack_reg <= 1'b1;
          sda_oe  <= (st_reg != flc_pkg::SER_RDATA);
          case (st_reg)
            flc_pkg::SER_DEVADDR: begin
              rw_reg <= sh_reg[0];
              if (sh_reg[7:1] != flc_pkg::SLAVE_ADDR) begin
                st_reg <= flc_pkg::SER_IDLE;
                sda_oe <= 1'b0;
              end
            end
            flc_pkg::SER_SUBADDR: ptr <= sh_reg;
            flc_pkg::SER_WDATA: begin
              wr_stb  <= 1'b1;
              wr_data <= sh_reg;
            end
            default: ptr <= ptr + 8'h01;
          endcase
        end else if (ack_reg) begin
          ack_reg <= 1'b0;
          cnt_reg <= 4'h0;
          sda_oe  <= 1'b0;
          if (st_reg == flc_pkg::SER_WDATA) ptr <= ptr + 8'h01;
          if ((st_reg == flc_pkg::SER_DEVADDR && rw_reg) || st_reg == flc_pkg::SER_RDATA) begin
            st_reg <= flc_pkg::SER_RDATA;
            sh_reg <= rd_data;
            sda_oe <= ~rd_data[7];
            rd_stb <= 1'b1;
          end else if (st_reg == flc_pkg::SER_DEVADDR) begin
            st_reg <= flc_pkg::SER_SUBADDR;
          end else begin
            st_reg <= flc_pkg::SER_WDATA;
          end
        end else if (st_reg == flc_pkg::SER_RDATA) begin
          sh_reg <= {sh_reg[6:0], 1'b0};
          sda_oe <= ~sh_reg[6];
        end
      end
    end
  end

endmodule

//--- hw/flc_regs_top.sv
`timescale 1ns/1ps
module flc_regs_top #(
  parameter int TICK_CYCLES = flc_pkg::TICK_CYCLES
) (
  input  wire logic  CORE_CLK,          // core clock
  input  wire logic  RST_N,             // async reset, active low
  input  wire logic  SCL_IN,            // serial clock pin
  input  wire logic  SDA_IN,            // serial data pin level
  output logic       SDA_OUT,           // serial data drive value
  output logic       SDA_OE,            // serial data drive enable
  input  wire logic  HW_TRIGGER_PIN,    // flash trigger pin
  input  wire logic  MIRROR_HIGH,       // mirror above short threshold
  input  wire logic  VOUT_OVER,         // output overvoltage
  input  wire logic  TEMP_WARN,         // sense above warning level
  input  wire logic  TEMP_HIGH,         // sense above high level
  input  wire logic  CHIP_OVERTEMP,     // die overtemperature
  input  wire logic  OVERCURRENT,       // inductor peak current
  input  wire logic  OUTPUT_NOT_OK,     // output failed to charge
  output logic       ATTENTION_N_OUT,   // attention drive value
  output logic       ATTENTION_N_OE,    // attention pull-low enable
  output logic       ANALOG_ENABLE,     // analog and power blocks on
  output logic       TEMP_COMP_ENABLE,  // temperature comparators on
  output logic [1:0] MODE,              // operating mode
  output logic       LED_ENABLE,        // main led current on
  output logic [3:0] CURRENT_INDEX,     // internal current index
  output logic [3:0] INDICATOR_CURRENT  // indicator current code
);

  logic [7:0] cmd_reg, led_dimming, aux_reg, stat_reg;
  logic [7:0] meta_reg, sync_reg;
  logic [2:0] open_hist_reg;
  logic [3:0] flash_cnt_reg, ind_cnt_reg;
  logic       ind_on_reg;
  flc_pkg::flc_mode_type mode_reg, mode_next;
  logic [7:0] ptr, wr_data, rd_value, stat_set, stat_view;
  logic       wr_stb, rd_stb, tick, sda_oe_i;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  flc_i2c_slave u_ser (
    .clk     (CORE_CLK),
    .rst_n   (RST_N),
    .scl_in  (SCL_IN),
    .sda_in  (SDA_IN),
    .sda_oe  (sda_oe_i),
    .rd_data (rd_value),
    .ptr     (ptr),
    .wr_stb  (wr_stb),
    .wr_data (wr_data),
    .rd_stb  (rd_stb)
  );

  flc_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .tick  (tick)
  );

  assign SDA_OE          = sda_oe_i;
  assign SDA_OUT         = 1'b0;
  assign ATTENTION_N_OUT = 1'b0;

  // ----------------------------------------------------------------
  // input synchronisers: hw_trigger_pin, mirror, vout, warn, high, ot, oc, nok
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      meta_reg      <= 8'h00;
      sync_reg      <= 8'h00;
      open_hist_reg <= 3'h0;
    end else begin
      meta_reg      <= {HW_TRIGGER_PIN, MIRROR_HIGH, VOUT_OVER, TEMP_WARN,
                        TEMP_HIGH, CHIP_OVERTEMP, OVERCURRENT, OUTPUT_NOT_OK};
      sync_reg      <= meta_reg;
      open_hist_reg <= {open_hist_reg[1:0], sync_reg[5]};
    end
  end

  // ----------------------------------------------------------------
  // mode control
  // ----------------------------------------------------------------
  wire power_on    = cmd_reg[flc_pkg::POWER_UP_BIT];
  wire flash_on    = cmd_reg[flc_pkg::SOFT_HW_TRIGGER_PIN_BIT] & sync_reg[7];
  wire led_mode    = (mode_reg == flc_pkg::MODE_TORCH) || (mode_reg == flc_pkg::MODE_FLASH);
  wire mon_active  = led_mode || (mode_reg == flc_pkg::MODE_READY &&
                                  cmd_reg[flc_pkg::TEMP_MON_BIT]);
  wire flash_exp   = (mode_reg == flc_pkg::MODE_FLASH) && (flash_cnt_reg == 4'h0);
  wire open_evt    = led_mode && sync_reg[5] && (&open_hist_reg);
  wire fault_force = led_mode && (open_evt || (mon_active && sync_reg[3]) ||
                                  sync_reg[2] || sync_reg[0]);
  wire stat_clr    = rd_stb && hit(ptr, flc_pkg::STAT_OFFSET);
  wire enter_sd    = (mode_next == flc_pkg::MODE_SHUTDOWN) &&
                     (mode_reg != flc_pkg::MODE_SHUTDOWN);

  always_comb begin
    if (!power_on) begin
      mode_next = flc_pkg::MODE_SHUTDOWN;
    end else if (fault_force || flash_exp) begin
      mode_next = flc_pkg::MODE_READY;
    end else if (flash_on) begin
      mode_next = flc_pkg::MODE_FLASH;
    end else if (cmd_reg[flc_pkg::TORCH_EN_BIT]) begin
      mode_next = flc_pkg::MODE_TORCH;
    end else begin
      mode_next = flc_pkg::MODE_READY;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) mode_reg <= flc_pkg::MODE_SHUTDOWN;
    else        mode_reg <= mode_next;
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmd_reg <= flc_pkg::CMD_RESET;
    end else begin
      if (wr_stb && hit(ptr, flc_pkg::CMD_OFFSET)) cmd_reg <= wr_data;
      if (flash_exp || fault_force) cmd_reg[flc_pkg::SOFT_HW_TRIGGER_PIN_BIT] <= 1'b0;
      if (fault_force) cmd_reg[flc_pkg::TORCH_EN_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      led_dimming <= flc_pkg::DIM_RESET;
      aux_reg <= flc_pkg::AUX_RESET;
    end else if (enter_sd) begin
      led_dimming <= flc_pkg::DIM_RESET;
      aux_reg <= flc_pkg::AUX_RESET;
    end else if (wr_stb) begin
      if (hit(ptr, flc_pkg::DIM_OFFSET)) led_dimming <= wr_data & 8'h77;
      if (hit(ptr, flc_pkg::AUX_OFFSET)) aux_reg <= wr_data;
    end
  end

  always_comb begin
    case (ptr)
      flc_pkg::CMD_OFFSET:  rd_value = cmd_reg;
      flc_pkg::DIM_OFFSET:  rd_value = led_dimming;
      flc_pkg::AUX_OFFSET:  rd_value = aux_reg;
      flc_pkg::STAT_OFFSET: rd_value = stat_view;
      default:              rd_value = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // flash countdown and indicator timer
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flash_cnt_reg <= 4'h0;
    end else if (wr_stb && hit(ptr, flc_pkg::CMD_OFFSET)) begin
      flash_cnt_reg <= wr_data[flc_pkg::FLASH_TIME_LSB +: 4];
    end else if (tick && mode_reg == flc_pkg::MODE_FLASH && flash_cnt_reg != 4'h0) begin
      flash_cnt_reg <= flash_cnt_reg - 4'h1;
    end
  end

  wire [3:0] ind_time = aux_reg[flc_pkg::IND_TIME_LSB +: 4];

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ind_on_reg  <= 1'b0;
      ind_cnt_reg <= 4'h0;
    end else if (enter_sd) begin
      ind_on_reg <= 1'b0;
    end else if (wr_stb && hit(ptr, flc_pkg::AUX_OFFSET)) begin
      ind_on_reg  <= (wr_data[flc_pkg::IND_CUR_LSB +: 4] != 4'h0) &&
                     (wr_data[flc_pkg::IND_TIME_LSB +: 4] != 4'h0);
      ind_cnt_reg <= wr_data[flc_pkg::IND_TIME_LSB +: 4];
    end else if (tick && ind_on_reg && ind_time != flc_pkg::IND_CONTINUOUS) begin
      ind_cnt_reg <= ind_cnt_reg - 4'h1;
      if (ind_cnt_reg <= 4'h1) ind_on_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // status flags and attention
  // ----------------------------------------------------------------
  always_comb begin
    stat_set = 8'h00;
    stat_set[flc_pkg::SHORTED_BIT]   = led_mode && sync_reg[6];
    stat_set[flc_pkg::OPEN_BIT]      = open_evt;
    stat_set[flc_pkg::TEMP_WARN_BIT] = mon_active && sync_reg[4];
    stat_set[flc_pkg::TEMP_HIGH_BIT] = mon_active && sync_reg[3];
    stat_set[flc_pkg::CHIP_OT_BIT]   = power_on && sync_reg[2];
    stat_set[flc_pkg::OUT_NOK_BIT]   = power_on && sync_reg[0];
    stat_view = stat_reg;
    stat_view[flc_pkg::FLASH_RUN_BIT] = (mode_reg == flc_pkg::MODE_FLASH);
    stat_view[flc_pkg::OVERCUR_BIT]   = sync_reg[1];
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      stat_reg       <= flc_pkg::STAT_RESET;
      ATTENTION_N_OE <= 1'b0;
    end else begin
      stat_reg       <= ((stat_clr ? 8'h00 : stat_reg) | stat_set) &
                        flc_pkg::LATCHED_MASK;
      ATTENTION_N_OE <= (ATTENTION_N_OE && !stat_clr) || (|stat_set) ||
                        flash_exp;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ANALOG_ENABLE     <= 1'b0;
      TEMP_COMP_ENABLE  <= 1'b0;
      MODE              <= 2'h0;
      LED_ENABLE        <= 1'b0;
      CURRENT_INDEX     <= 4'h0;
      INDICATOR_CURRENT <= 4'h0;
    end else begin
      ANALOG_ENABLE    <= (mode_reg != flc_pkg::MODE_SHUTDOWN);
      TEMP_COMP_ENABLE <= mon_active;
      MODE             <= mode_reg;
      LED_ENABLE       <= led_mode;
      case (mode_reg)
        flc_pkg::MODE_TORCH: CURRENT_INDEX <= {1'b0, led_dimming[flc_pkg::TORCH_LVL_LSB +: 3]};
        flc_pkg::MODE_FLASH: CURRENT_INDEX <= {1'b0, led_dimming[flc_pkg::FLASH_LVL_LSB +: 3]}
                                              + flc_pkg::FLASH_INDEX_OFS;
        default:             CURRENT_INDEX <= 4'h0;
      endcase
      INDICATOR_CURRENT <= (mode_reg == flc_pkg::MODE_READY && ind_on_reg) ?
                           aux_reg[flc_pkg::IND_CUR_LSB +: 4] : 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  flash_needs_power_a: assert property (mode_reg == flc_pkg::MODE_FLASH |->
    $past(power_on) && $past(flash_on)) else $error("flash without power or trigger");
  flash_trigger_and_a: assert property (!flash_on |=>
    mode_reg != flc_pkg::MODE_FLASH) else $error("flash without trigger and");
  torch_index_a: assert property (mode_reg == flc_pkg::MODE_TORCH |=>
    CURRENT_INDEX == {1'b0, $past(led_dimming[6:4])}) else $error("torch index wrong");
  flash_index_a: assert property (mode_reg == flc_pkg::MODE_FLASH |=>
    CURRENT_INDEX == {1'b0, $past(led_dimming[2:0])} + 4'h5) else $error("flash index wrong");
  timeout_end_a: assert property (flash_exp |=>
    !cmd_reg[6] && mode_reg != flc_pkg::MODE_FLASH && ATTENTION_N_OE)
    else $error("timeout did not end flash");
  read_release_a: assert property (stat_clr && stat_set == 8'h00 && !flash_exp |=>
    !ATTENTION_N_OE) else $error("attention not released");
  flag_set_wins_a: assert property (stat_set[7] |=> stat_reg[7])
    else $error("shorted flag lost");
  indicator_off_a: assert property (mode_reg != flc_pkg::MODE_READY |=>
    INDICATOR_CURRENT == 4'h0) else $error("indicator on outside ready");
  shutdown_dim_a: assert property (enter_sd |=> led_dimming == 8'h00 &&
    aux_reg == 8'h00) else $error("dimming not cleared");
  open_force_a: assert property (open_evt |=>
    mode_reg != flc_pkg::MODE_FLASH && mode_reg != flc_pkg::MODE_TORCH)
    else $error("open led did not force ready");

  flash_seen_c:   cover property (mode_reg == flc_pkg::MODE_FLASH ##1 flash_exp);
  torch_seen_c:   cover property (mode_reg == flc_pkg::MODE_TORCH);
  stat_read_c:    cover property (ATTENTION_N_OE ##1 stat_clr);
  indicator_on_c: cover property (INDICATOR_CURRENT != 4'h0);

endmodule

//--- tb/flc_master.sv
`timescale 1ns/1ps
module flc_master (
  input  wire logic clk,    // core clock
  input  wire logic dev_oe, // device pulls data low
  output logic      scl,    // serial clock
  output logic      sda     // wired data level
);
  logic m_oe = 1'b0;
  initial scl = 1'b1;
  // pull-up: released line reads high
  assign sda = !(m_oe | dev_oe);
  task automatic hc();
    repeat (10) @(negedge clk);
  endtask
  // data moves only while scl is low, sampled mid-high
  task automatic bitx(input logic b, output logic v);
    repeat (3) @(negedge clk);
    m_oe = !b;
    hc();
    scl = 1'b1;
    repeat (5) @(negedge clk);
    v = sda;
    repeat (5) @(negedge clk);
    scl = 1'b0;
  endtask
  task automatic start();
    repeat (3) @(negedge clk);
    m_oe = 1'b0;
    hc();
    scl = 1'b1;
    hc();
    m_oe = 1'b1;
    hc();
    scl = 1'b0;
  endtask
  task automatic stop();
    repeat (3) @(negedge clk);
    m_oe = 1'b1;
    hc();
    scl = 1'b1;
    hc();
    m_oe = 1'b0;
    hc();
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic v);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(a, v);
  endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hw_trigger_pin = 1'b1;
  logic        tw = 1'b0;
  logic        oc = 1'b0;
  logic        mir = 1'b0;
  logic        vout = 1'b0;
  wire         scl, sda;
  logic        sda_oe, att_oe, ae, le, tce;
  logic [1:0]  mode;
  logic [3:0]  idx, ind, cur;
  logic [31:0] q, r;
  logic [7:0]  dim;
  int          bad_count = 0;
  int          compares = 0;
  int          n;
  int          fl_total = 0;
  int          f0;
  always #5 core_clk = !core_clk;
  flc_master u_host (.clk(core_clk), .dev_oe(sda_oe), .scl(scl), .sda(sda));
  flc_regs_top #(.TICK_CYCLES(100)) u_dut (.CORE_CLK(core_clk), .RST_N(rst_n), .SCL_IN(scl),
    .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe), .HW_TRIGGER_PIN(hw_trigger_pin), .MIRROR_HIGH(mir),
    .VOUT_OVER(vout), .TEMP_WARN(tw), .TEMP_HIGH(1'b0), .CHIP_OVERTEMP(1'b0),
    .OVERCURRENT(oc), .OUTPUT_NOT_OK(1'b0), .ATTENTION_N_OUT(), .ATTENTION_N_OE(att_oe),
    .ANALOG_ENABLE(ae), .TEMP_COMP_ENABLE(tce), .MODE(mode), .LED_ENABLE(le),
    .CURRENT_INDEX(idx), .INDICATOR_CURRENT(ind));
  // cycles spent in flash mode, for the time limit check
  always @(negedge core_clk) begin
    if (mode == 2'b10) fl_total++;
  end
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int k);
    logic [47:0] w;
    logic [7:0]  x;
    logic        v;
    w = {16'h0, d} | ({40'h0, flc_pkg::SLAVE_ADDR, 1'b0} << 8 * (k + 1)) | ({40'h0, a} << 8 * k);
    u_host.start();
    for (int i = k + 1; i >= 0; i--) begin
      u_host.xfer(w[8*i +: 8], 1'b1, x, v);
      chk("ack", 32'h0, {31'h0, v});
    end
    u_host.stop();
  endtask
  task automatic rd(input logic [7:0] a, input int k, output logic [31:0] d);
    logic [7:0] x;
    logic       v;
    d = '0;
    u_host.start();
    u_host.xfer({flc_pkg::SLAVE_ADDR, 1'b0}, 1'b1, x, v);
    u_host.xfer(a, 1'b1, x, v);
    u_host.start();
    u_host.xfer({flc_pkg::SLAVE_ADDR, 1'b1}, 1'b1, x, v);
    for (int i = k - 1; i >= 0; i--) begin
      u_host.xfer(8'hFF, i == 0, x, v);
      d[8*i +: 8] = x;
    end
    u_host.stop();
  endtask
  task automatic waitm(input logic [1:0] m);
    for (n = 0; n < 400 && mode !== m; n++) @(negedge core_clk);
    if (n == 400) begin
      bad_count++;
      close_out();
    end
  endtask
  initial begin
    void'($urandom(8));
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (5) @(negedge core_clk);
    rd(8'h00, 4, q);
    chk("reset", 32'h0, q);
    r = $urandom;
    dim = r[15:8] & 8'h77;
    cur = r[27:24] | 4'h1;
    wr(8'h00, {2'b00, r[21:16], r[15:8], r[7:0], 8'hFF}, 4);
    rd(8'h00, 4, q);
    chk("regs", {2'b00, r[21:16], dim, r[7:0], 8'h00}, q);
    wr(8'h00, 32'h80, 1);
    waitm(2'b01);
    chk("ready", 32'h2, {30'h0, ae, tce});
    wr(8'h02, {24'h0, cur, 4'h2}, 1);
    chk("indon", {28'h0, cur}, {28'h0, ind});
    repeat (200) @(negedge core_clk);
    chk("indtime", 32'h0, {28'h0, ind});
    wr(8'h02, {24'h0, cur, 4'hF}, 1);
    repeat (250) @(negedge core_clk);
    chk("indcont", {28'h0, cur}, {28'h0, ind});
    wr(8'h00, 32'hA0, 1);
    waitm(2'b11);
    chk("torch", {24'h0, 4'hE, 1'b0, dim[6:4]},
        {24'h0, ae, le, tce, 1'b0, idx});
    chk("indoff", 32'h0, {28'h0, ind});
    mir = 1'b1;
    repeat (10) @(negedge core_clk);
    mir = 1'b0;
    chk("satn", 32'h1, {31'h0, att_oe});
    rd(8'h03, 1, q);
    chk("short", 32'h80, q);
    vout = 1'b1;
    waitm(2'b01);
    vout = 1'b0;
    chk("indback", {28'h0, cur}, {28'h0, ind});
    rd(8'h03, 1, q);
    chk("open", 32'h20, q);
    rd(8'h00, 1, q);
    chk("tclr", 32'h80, q);
    f0 = fl_total;
    wr(8'h00, 32'hC3, 1);
    waitm(2'b10);
    chk("flash", {29'h0, dim[2:0]} + 32'h5, {28'h0, idx});
    waitm(2'b01);
    n = fl_total - f0;
    chk("fltime", 32'h1, {31'h0, n >= 200 && n <= 305});
    chk("atn", 32'h1, {31'h0, att_oe});
    rd(8'h00, 1, q);
    chk("cmd", 32'h83, q);
    rd(8'h03, 1, q);
    chk("stat", 32'h0, {23'h0, q[7:0], att_oe});
    hw_trigger_pin = 1'b0;
    wr(8'h00, 32'hCF, 1);
    repeat (10) @(negedge core_clk);
    chk("hwwait", 32'h1, {30'h0, mode});
    hw_trigger_pin = 1'b1;
    waitm(2'b10);
    rd(8'h03, 1, q);
    chk("frun", 32'h40, q);
    hw_trigger_pin = 1'b0;
    waitm(2'b01);
    wr(8'h00, 32'h90, 1);
    chk("mon", 32'h1, {31'h0, tce});
    tw = 1'b1;
    oc = 1'b1;
    repeat (10) @(negedge core_clk);
    tw = 1'b0;
    chk("warn", 32'h1, {31'h0, att_oe});
    rd(8'h03, 1, q);
    chk("latch", 32'h12, q);
    oc = 1'b0;
    rd(8'h03, 1, q);
    chk("clear", 32'h0, {23'h0, q[7:0], att_oe});
    wr(8'h00, 32'h00, 1);
    rd(8'h01, 2, q);
    chk("shut", 32'h0, {q[15:0], 11'h0, ind, ae});
    close_out();
  end
endmodule
